// [logic/actuator_defs.svh]
/*
 Bit positions and timing counts for the actuator
 control/status bank. Assumes a 200 MHz system clock.
*/
// Functional notes
// - Writing the global enable bit as one moves the device from standby into active operation.
// - Writing the global enable bit as zero puts the device in standby and clears all control and status bits.
// - After power-on reset the device sits in standby with the global enable off.
// - The top status bit always reads one, so an all-zero or all-one frame is recognised as broken.
// - An overcurrent on an output sets its overcurrent flag and switches that output off.
// - With auto-recovery enabled the output retries after a delay whose length follows the duty select.
// - A single recovery cycle with auto-recovery disabled is tolerated but not produced here.
// - Overvoltage or undervoltage sets its status flag and deactivates all outputs.
// - When the supply returns to normal the outputs come back without any software action.
// - A thermal shutdown sets its flag and switches every output off.
// - The thermal shutdown flag and output lock stay until the reset bit clears them.
// - The temperature warning flag is held until the reset bit clears it.
// - Leaving standby starts a settling timer and no output turns on before it expires.
// - The not-ready flag is set exactly for the settling interval, timed by the system clock.
// - Status bit zero is the NOR of status bits 1 to 22 of both status registers.
`ifndef ACTUATOR_DEFS_SVH
`define ACTUATOR_DEFS_SVH
`define FRAME_BITS 24
`define IN_ENABLE_BIT 23
`define IN_REC_C_BIT 22
`define IN_REC_B_BIT 20
`define IN_REC_A_BIT 19
`define IN_SELECT_BIT 0
`define ST_ALWAYS1_BIT 23
`define ST_OVERVOLT_BIT 22
`define ST_UNDERVOLT_BIT 21
`define ST_TSD_BIT 20
`define ST_TW_BIT 19
`define ST_NOT_READY_BIT 18
`define ST_NO_ERROR_BIT 0
`define SYS_CLK_MHZ 200
`define STARTUP_TIME_US 100
`define STARTUP_CYCLES (`STARTUP_TIME_US * `SYS_CLK_MHZ)
`define REC_OFF_SHORT_NS 1000
`define REC_OFF_LONG_NS 4000
`define REC_SHORT_CYCLES ((`REC_OFF_SHORT_NS * `SYS_CLK_MHZ + 999) / 1000)
`define REC_LONG_CYCLES ((`REC_OFF_LONG_NS * `SYS_CLK_MHZ + 999) / 1000)
`endif

// [logic/actuator_pkg.sv]
/*
 Types shared by the actuator control/status bank.
 Assumes the defs header supplies all numbers.
*/
package actuator_pkg;

    // Operating mode of the bank
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_SETTLE = 2'b01,
        MODE_ACTIVE = 2'b10
    } op_mode_e;

    typedef logic [23:0] frame_t;

endpackage : actuator_pkg

// [logic/actuator_spi_ctrl_status_bank.sv]
/*
 Control/status bank for the second input and status register pair:
 global enable, highside overcurrent recovery enables, supply and
 temperature flags, start-up not-ready flag and the no-error bit.
 Assumes analogue detectors arrive asynchronously, the reset bit and
 duty select come from the first register pair on sys_clk, and the
 SPI master runs mode 1 with chip select high between frames.
 Standby gates every output on the edge at which it begins.
*/
`timescale 1ns/1ps
`include "actuator_defs.svh"
module actuator_spi_ctrl_status_bank
    import actuator_pkg::*;
#(
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic power_supply_rail_ov_det,
    input wire logic power_supply_rail_uv_det,
    input wire logic thermal_shutdown_det,
    input wire logic temp_warning_det,
    input wire logic [2:0] highside_oc_det,
    input wire logic reset_bit,
    input wire logic long_recovery,
    input wire logic status0_error,
    input wire logic [16:0] status1_low,
    output logic active_mode,
    output logic not_ready,
    output logic clear_all,
    output logic [2:0] highside_output_on,
    output logic [2:0] oc_flag,
    output logic ov_flag,
    output logic uv_flag,
    output logic thermal_shutdown_flag,
    output logic temp_warning_flag
);

    ////////////////////////////////////////////////////////////////
    // Declarations

    // Sticky flag: set beats clear
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    spi_link_if lnk ();

    // Two synchroniser stages, one bit per asynchronous level
    logic [8:0] sync1;
    logic [8:0] sync2;
    // Last synchronised frame marker, for the edge detect
    logic done_d;
    // Mode state and its start-up count
    op_mode_e mode;
    op_mode_e next_mode;
    logic [19:0] settle_cnt;
    // Recovery enables as last written
    logic [2:0] rec_en;
    // Snapshot handed to the link between frames
    frame_t stat_hold;
    // Per-output drive lock from the recovery blocks
    logic [2:0] oc_off;
    // Latched overcurrent flags ahead of the port flop
    logic [2:0] oc_flag_w;

    ////////////////////////////////////////////////////////////////
    // Link side

    // Shifters run wholly on the serial clock
    spi_link u_link (
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .lnk(lnk.link)
    );

    ////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for pins and link-domain levels

    // Chip select idles high, hence the set top bit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1 <= 9'h100;
            sync2 <= 9'h100;
            done_d <= 1'b0;
        end
        else
        begin
            sync1 <= {spi_cs_n, lnk.frame_done, highside_oc_det,
                      temp_warning_det, thermal_shutdown_det,
                      power_supply_rail_uv_det, power_supply_rail_ov_det};
            sync2 <= sync1;
            done_d <= sync2[7];
        end
    end

    // Named views of the synchronised levels
    wire ov_s = sync2[0];
    wire uv_s = sync2[1];
    wire tsd_s = sync2[2];
    wire tw_s = sync2[3];
    wire [2:0] oc_s = sync2[6:4];
    wire cs_idle_s = sync2[8];

    ////////////////////////////////////////////////////////////////
    // Frame decode

    // Word is stable: the link will not rewrite it before next frame end
    wire new_frame = sync2[7] & ~done_d;
    // Only frames addressed to this register pair take effect
    wire wr_reg1 = new_frame & lnk.rx_word[`IN_SELECT_BIT];
    wire wr_enable = wr_reg1 & lnk.rx_word[`IN_ENABLE_BIT];
    wire wr_disable = wr_reg1 & ~lnk.rx_word[`IN_ENABLE_BIT];
    wire in_standby = (mode == MODE_STANDBY);
    wire settle_done = (settle_cnt == 20'(STARTUP_CYCLES - 1));

    ////////////////////////////////////////////////////////////////
    // Mode sequencing

    // An enable written again while awake leaves the timer alone
    always_comb
    begin
        next_mode = mode;
        case (mode)
            MODE_STANDBY:
            begin
                if (wr_enable)
                    next_mode = MODE_SETTLE; // Start charge pump wait
            end
            MODE_SETTLE:
            begin
                if (wr_disable)
                    next_mode = MODE_STANDBY;
                else if (settle_done)
                    next_mode = MODE_ACTIVE;
            end
            MODE_ACTIVE:
            begin
                if (wr_disable)
                    next_mode = MODE_STANDBY;
            end
            default:
            begin
                next_mode = MODE_STANDBY;
            end
        endcase
    end

    // Mode register; reset lands in standby
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mode <= MODE_STANDBY;
        else
            mode <= next_mode;
    end

    // Settling counter, runs only while settling
    // Holds its end value until the mode moves on
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || mode != MODE_SETTLE)
            settle_cnt <= 20'h00000;
        else if (!settle_done)
            settle_cnt <= settle_cnt + 20'h00001;
    end

    ////////////////////////////////////////////////////////////////
    // Control bits of the input register

    // Recovery bits follow only an enable write
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rec_en <= 3'h0;
        else if (wr_disable)
            rec_en <= 3'h0; // Standby clears control bits
        else if (wr_enable)
        begin
            rec_en <= {lnk.rx_word[`IN_REC_C_BIT],
                       lnk.rx_word[`IN_REC_B_BIT],
                       lnk.rx_word[`IN_REC_A_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags; detectors are ignored in standby

    // Reset bit is moot in standby, where every flag is zero anyway
    wire flag_clr = reset_bit & ~in_standby;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || wr_disable || in_standby)
        begin
            ov_flag <= 1'b0;
            uv_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            temp_warning_flag <= 1'b0;
        end
        else
        begin
            ov_flag <= sticky(ov_flag, ov_s, flag_clr);
            uv_flag <= sticky(uv_flag, uv_s, flag_clr);
            thermal_shutdown_flag <= sticky(thermal_shutdown_flag, tsd_s, flag_clr);
            temp_warning_flag <= sticky(temp_warning_flag, tw_s, flag_clr);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Overcurrent latch and retry per highside output (0=a, 1=b, 2=c)

    // A trip in the disable cycle would outlive that clear, so it is dropped
    wire trip_gate = ~in_standby & ~wr_disable;
    // Clear held through standby so nothing stays latched there
    wire oc_clear = flag_clr | wr_disable | in_standby;

    for (genvar i = 0; i < 3; i++)
    begin : g_oc
        oc_recovery u_rec (
            .clk(sys_clk),
            .rst(sys_rst),
            .trip(oc_s[i] & trip_gate),
            .rec_en(rec_en[i]),
            .long_off(long_recovery),
            .clear(oc_clear),
            .oc_flag(oc_flag_w[i]),
            .oc_off(oc_off[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    // Output gating

    // Supply faults gate live, so recovery needs no software
    wire supply_ok = ~ov_s & ~uv_s;
    // Shutdown lock stays until the reset bit clears the flag
    wire heat_ok = ~thermal_shutdown_flag;
    // Next mode, so a disable write drops the drive on its own edge
    wire mode_ok = (next_mode == MODE_ACTIVE);
    wire outputs_ok = mode_ok & supply_ok & heat_ok;
    wire [2:0] drive_next = {3{outputs_ok}} & ~oc_off;

    // Every port value leaves from a flop
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            highside_output_on <= 3'h0;
            oc_flag <= 3'h0;
            active_mode <= 1'b0;
            not_ready <= 1'b0;
            clear_all <= 1'b0;
        end
        else
        begin
            highside_output_on <= drive_next;
            oc_flag <= oc_flag_w;
            active_mode <= (next_mode != MODE_STANDBY);
            not_ready <= (next_mode == MODE_SETTLE); // Only while settling
            clear_all <= wr_disable; // Tells the other register pair to clear
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status word

    // NOR of bits 1..22 of both status registers
    wire any_error = ov_flag | uv_flag | thermal_shutdown_flag
                     | temp_warning_flag | not_ready
                     | (|status1_low) | status0_error;

    // Bits 17..1 are the other half of this status register
    wire [23:0] stat_next = {1'b1,
                             ov_flag,
                             uv_flag,
                             thermal_shutdown_flag,
                             temp_warning_flag,
                             not_ready,
                             status1_low,
                             ~any_error};

    // Snapshot refreshed only between frames, so the link reads a
    // quiet word; costs up to three cycles of staleness.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            stat_hold <= 24'h800001;
        else if (cs_idle_s)
            stat_hold <= stat_next;
    end

    assign lnk.stat_word = stat_hold;

endmodule : actuator_spi_ctrl_status_bank

// [logic/oc_recovery.sv]
/*
 Overcurrent latch and retry timer for one highside output.
 Assumes trip is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "actuator_defs.svh"
module oc_recovery
    import actuator_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic trip,
    input wire logic rec_en,
    input wire logic long_off,
    input wire logic clear,
    output logic oc_flag,
    output logic oc_off
);

    logic [11:0] timer;
    wire timer_done = (timer == 12'h000);
    wire new_trip = trip && !oc_off;

    ////////////////////////////////////////////////////////////////
    // Trip wins over a clear arriving in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            oc_flag <= 1'b0;
            oc_off <= 1'b0;
            timer <= 12'h000;
        end
        else if (new_trip)
        begin
            oc_flag <= 1'b1; // Latch the event
            oc_off <= 1'b1; // Output off
            timer <= long_off ? 12'(`REC_LONG_CYCLES - 1) : 12'(`REC_SHORT_CYCLES - 1);
        end
        else if (clear)
        begin
            oc_flag <= 1'b0; // Software clear via reset bit
            oc_off <= 1'b0;
            timer <= 12'h000;
        end
        else if (oc_off && rec_en)
        begin
            // Retry only when enabled; no spurious retry otherwise
            if (timer_done)
                oc_off <= 1'b0; // Auto retry, flag stays set
            else
                timer <= timer - 12'h001;
        end
    end

endmodule : oc_recovery

// [logic/spi_link.sv]
/*
 Serial shift logic on the link clock: mode 1, MSB first, 24 bits.
 Assumes the master keeps chip select high between frames long
 enough for the core to see frame_done rise and fall.
*/
`timescale 1ns/1ps
module spi_link
    import actuator_pkg::*;
(
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    spi_link_if.link lnk
);

    logic [4:0] tx_cnt;
    logic [23:0] tx_sh;
    logic [4:0] rx_cnt;
    logic [23:0] rx_sh;
    logic done;

    ////////////////////////////////////////////////////////////////
    // Transmit on rising edge; chip select high parks the shifter
    always_ff @(posedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            tx_cnt <= 5'h00;
            tx_sh <= 24'h000000;
            spi_miso <= 1'b0;
        end
        else if (tx_cnt == 5'h00)
        begin
            spi_miso <= lnk.stat_word[23]; // Always-one bit leads
            tx_sh <= {lnk.stat_word[22:0], 1'b0};
            tx_cnt <= 5'h01;
        end
        else
        begin
            spi_miso <= tx_sh[23];
            tx_sh <= {tx_sh[22:0], 1'b0};
            tx_cnt <= (tx_cnt == 5'h18) ? tx_cnt : tx_cnt + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Receive on falling edge; done stays up until chip select rises
    always_ff @(negedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            rx_cnt <= 5'h00;
            rx_sh <= 24'h000000;
            done <= 1'b0;
        end
        else
        begin
            rx_sh <= {rx_sh[22:0], spi_mosi};
            rx_cnt <= (rx_cnt == 5'h18) ? rx_cnt : rx_cnt + 5'h01;
            if (rx_cnt == 5'h17)
                done <= 1'b1; // The 24th bit completes a frame
        end
    end

    // Word capture; data only, so no reset needed
    always_ff @(negedge spi_sck)
    begin
        if (!spi_cs_n && rx_cnt == 5'h17 && !done)
            lnk.rx_word <= {rx_sh[22:0], spi_mosi};
    end

    assign lnk.frame_done = done;

endmodule : spi_link

// [logic/spi_link_if.sv]
/*
 Carrier between the serial link and the register core.
 Assumes the core holds stat_word stable while chip select is low.
*/
`timescale 1ns/1ps
interface spi_link_if;
    import actuator_pkg::*;

    frame_t rx_word;
    logic frame_done;
    frame_t stat_word;

    modport link (output rx_word, output frame_done, input stat_word);
    modport core (input rx_word, input frame_done, output stat_word);
endinterface : spi_link_if

// [verification/actuator_monitor.sv]
/*
 Port checker for the control/status bank, sys_clk side only.
 Assumes it is bound to the bank's top module.
*/
`timescale 1ns/1ps
module actuator_monitor
#(
    parameter int STARTUP_CYCLES = 20
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_bit,
    input wire logic active_mode,
    input wire logic not_ready,
    input wire logic clear_all,
    input wire logic [2:0] highside_output_on,
    input wire logic [2:0] oc_flag,
    input wire logic ov_flag,
    input wire logic uv_flag,
    input wire logic thermal_shutdown_flag,
    input wire logic temp_warning_flag
);
    int settle_len;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Counter, as the settle interval is too long to unroll
    always_ff @(posedge sys_clk)
        settle_len <= not_ready ? settle_len + 1 : 0;
    sequence settle_end_s;
        not_ready ##1 !not_ready && active_mode;
    endsequence
    sequence heat_held_s;
        thermal_shutdown_flag && !reset_bit && !clear_all ##1 active_mode && !clear_all;
    endsequence
    chk_settle_gate: assert property (not_ready |-> highside_output_on == 3'b000)
        else $error("output driven while settling");
    chk_settle_length: assert property (settle_end_s |-> settle_len == STARTUP_CYCLES)
        else $error("settle interval length wrong");
    chk_wake_start: assert property ($rose(not_ready) |-> active_mode && !$past(active_mode))
        else $error("settle began outside a wake");
    chk_drive_needs_active: assert property (highside_output_on != 3'b000 |-> active_mode && !not_ready)
        else $error("output driven in standby");
    chk_standby_clear: assert property (clear_all |=> !active_mode && oc_flag == 3'b000 && !ov_flag
        && !uv_flag && !thermal_shutdown_flag && !temp_warning_flag)
        else $error("standby left flags set");
    chk_heat_gate: assert property (thermal_shutdown_flag ##1 thermal_shutdown_flag
        |-> highside_output_on == 3'b000)
        else $error("output on during shutdown");
    chk_heat_hold: assert property (heat_held_s |-> thermal_shutdown_flag)
        else $error("shutdown flag dropped alone");
    chk_warn_hold: assert property ($past(temp_warning_flag) && !$past(reset_bit) &&
        !$past(clear_all) && active_mode && !clear_all |-> temp_warning_flag)
        else $error("warning flag dropped alone");
    chk_trip_off: assert property ((oc_flag & ~$past(oc_flag)) != 3'b000 |=>
        (highside_output_on & $past(oc_flag) & ~$past(oc_flag, 2)) == 3'b000)
        else $error("tripped output still on");
endmodule : actuator_monitor
////////////////////////////////////////
bind actuator_spi_ctrl_status_bank actuator_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_actuator_monitor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_bit(reset_bit), .active_mode(active_mode),
    .not_ready(not_ready), .clear_all(clear_all), .highside_output_on(highside_output_on),
    .oc_flag(oc_flag), .ov_flag(ov_flag), .uv_flag(uv_flag),
    .thermal_shutdown_flag(thermal_shutdown_flag), .temp_warning_flag(temp_warning_flag));

// [verification/spi_master_model.sv]
/*
 Microcontroller side of the link: mode 1 master, 48 ns clock.
 Assumes the device shifts on rising and samples on falling edges.
*/
`timescale 1ns/1ps
module spi_master_model
    import actuator_pkg::*;
(
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b0;
        spi_mosi = 1'b0;
        // A clean rising edge parks the device's shifters before reset ends
        #1;
        spi_cs_n = 1'b1;
    end
    // One 24 bit full-duplex frame, MSB first
    task automatic xfer(input frame_t tx, output frame_t rx, output logic ok);
        spi_cs_n = 1'b0;
        #24;
        for (int i = 23; i >= 0; i--)
        begin
            spi_sck = 1'b1;
            spi_mosi = tx[i];
            #24;
            spi_sck = 1'b0;
            rx[i] = spi_miso;
            #24;
        end
        spi_cs_n = 1'b1;
        // Released line never shows the last bit
        spi_mosi = ~tx[0];
        ok = (rx !== 24'h000000) && (rx !== 24'hffffff);
        #100;
    endtask : xfer
endmodule : spi_master_model

// [verification/test_actuator_spi_ctrl_status_bank.sv]
/*
 Self-checking bench for the control/status bank.
 Assumes the master model drives the link at 48 ns.
*/
`timescale 1ns/1ps
module test_actuator_spi_ctrl_status_bank;
    import actuator_pkg::*;
    localparam int SETTLE = 400;
    logic sys_clk, sys_rst, reset_bit, long_recovery, status0_error;
    logic ov_det, uv_det, hot_det, warn_det, ok;
    logic spi_sck, spi_cs_n, spi_mosi, spi_miso;
    logic act_q, nr_q, clr_q, ov_q, uv_q, hot_q, warn_q;
    logic [2:0] oc_det, on_q, oc_q, m_oc, m_off;
    logic [16:0] low_bits;
    logic m_act, m_nr;
    logic [3:0] m_flg;
    frame_t rx;
    frame_t exp_q[$];
    int bad_count, samples_checked, cycles, clr_seen;

    spi_master_model i_spi_master_model (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso));
    actuator_spi_ctrl_status_bank #(.STARTUP_CYCLES(SETTLE)) i_actuator_spi_ctrl_status_bank (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .power_supply_rail_ov_det(ov_det),
        .power_supply_rail_uv_det(uv_det), .thermal_shutdown_det(hot_det), .temp_warning_det(warn_det),
        .highside_oc_det(oc_det), .reset_bit(reset_bit), .long_recovery(long_recovery),
        .status0_error(status0_error), .status1_low(low_bits), .active_mode(act_q), .not_ready(nr_q),
        .clear_all(clr_q), .highside_output_on(on_q), .oc_flag(oc_q), .ov_flag(ov_q), .uv_flag(uv_q),
        .thermal_shutdown_flag(hot_q), .temp_warning_flag(warn_q));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard; the run needs well under 8000 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    ////////////////////////////////////////
    // Clear pulses, counted while they stand
    always @(negedge sys_clk)
        if (clr_q === 1'b1)
            clr_seen++;
    // Reference model outputs
    function automatic logic [11:0] exp_ports();
        logic [2:0] on;
        on = (m_act && !m_nr && !ov_det && !uv_det && !m_flg[1]) ? ~m_off : 3'b000;
        return {m_act, m_nr, on, m_flg, m_oc};
    endfunction : exp_ports
    function automatic frame_t exp_stat();
        frame_t w;
        w = {1'b1, m_flg, m_nr, low_bits, 1'b0};
        w[0] = ~(|w[22:1] | status0_error);
        return w;
    endfunction : exp_stat
    task automatic cmp_frame(input frame_t got, input frame_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_frame
    task automatic cmp_port(input logic [11:0] exp);
        cmp_frame({12'h000, act_q, nr_q, on_q, ov_q, uv_q, hot_q, warn_q, oc_q}, {12'h000, exp});
    endtask : cmp_port
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    // Frame exchange; side inputs change only well after chip select rises
    task automatic xchg(input frame_t w);
        exp_q.push_back(exp_stat());
        i_spi_master_model.xfer(w, rx, ok);
        step(1);
        cmp_frame(rx, exp_q.pop_front());
        cmp_frame({23'h0, ok}, 24'h000001);
        low_bits = 17'($urandom);
        status0_error = 1'($urandom);
        step(4);
    endtask : xchg
    task automatic pulse_reset();
        reset_bit = 1'b1;
        step(1);
        reset_bit = 1'b0;
        m_flg = 4'h0;
        m_oc = 3'b000;
        m_off = 3'b000;
        step(3);
    endtask : pulse_reset
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        {sys_rst, reset_bit, long_recovery, status0_error} = 4'b1000;
        {ov_det, uv_det, hot_det, warn_det, oc_det} = 7'h00;
        {m_act, m_nr, m_flg, m_oc, m_off} = 12'h000;
        void'($urandom(73));
        low_bits = 17'($urandom);
        step(20);
        sys_rst = 1'b0;
        step(5);
        cmp_port(exp_ports());
        xchg(24'h800000);
        cmp_port(exp_ports());
        xchg(24'hc80001);
        {m_act, m_nr} = 2'b11;
        step(40);
        cmp_port(exp_ports());
        xchg(24'h000000);
        for (int n = 0; n < 2 * SETTLE && nr_q !== 1'b0; n++)
            step(1);
        m_nr = 1'b0;
        step(2);
        cmp_port(exp_ports());
        for (int k = 0; k < 4; k++)
        begin
            {ov_det, uv_det, hot_det, warn_det} = 4'b1000 >> k;
            m_flg = 4'b1000 >> k;
            step(6);
            cmp_port(exp_ports());
            xchg(24'h000000);
            {ov_det, uv_det, hot_det, warn_det} = 4'h0;
            step(6);
            cmp_port(exp_ports());
            pulse_reset();
            cmp_port(exp_ports());
        end
        for (int k = 0; k < 2; k++)
        begin
            long_recovery = k[0];
            oc_det = 3'b111;
            step(1);
            oc_det = 3'b000;
            {m_oc, m_off} = 6'h3f;
            step(k ? 700 : 180);
            cmp_port(exp_ports());
            step(k ? 130 : 30);
            m_off = 3'b010;
            cmp_port(exp_ports());
            pulse_reset();
            cmp_port(exp_ports());
        end
        warn_det = 1'b1;
        step(6);
        m_flg = 4'h1;
        xchg(24'h000001);
        {m_act, m_flg} = 5'h00;
        cmp_port(exp_ports());
        cmp_frame(24'(clr_seen), 24'h000001);
        warn_det = 1'b0;
        summarize();
    end
endmodule : test_actuator_spi_ctrl_status_bank
